// >>> hdl/tpwm_defines.svh
// Register offsets, field positions, reset values and codes of the timer
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH
// Byte offsets of the shared registers
`define TPWM_OFS_TSC 6'h00
`define TPWM_OFS_CNTH 6'h04
`define TPWM_OFS_CNTL 6'h08
`define TPWM_OFS_MODH 6'h0c
`define TPWM_OFS_MODL 6'h10
// Channel register block: base, stride and offsets inside the block
`define TPWM_OFS_CH_BASE 6'h14
`define TPWM_CH_STRIDE 6'h0c
`define TPWM_OFS_CH_SC 6'h00
`define TPWM_OFS_CH_VH 6'h04
`define TPWM_OFS_CH_VL 6'h08
// Field positions of timer_status_control
`define TPWM_TSC_TOF 7
`define TPWM_TSC_OVERFLOW_IRQ_ENABLE 6
`define TPWM_TSC_CAS 5
`define TPWM_TSC_CLKS_LO 3
`define TPWM_TSC_PS_LO 0
// Field positions of channel_status_control
`define TPWM_CSC_FLAG 7
`define TPWM_CSC_IE 6
`define TPWM_CSC_MSB 5
`define TPWM_CSC_MSA 4
`define TPWM_CSC_ELS_LO 2
// Reset values and the all-ones count limit
`define TPWM_RST_BYTE 8'h00
`define TPWM_RST_WORD 16'h0000
`define TPWM_RST_PS 3'h0
`define TPWM_CNT_MAX 16'hffff
// Edge-level select codes
`define TPWM_ELS_OFF 2'h0
`define TPWM_ELS_01 2'h1
`define TPWM_ELS_10 2'h2
`define TPWM_ELS_11 2'h3
`endif

// >>> hdl/tpwm_pkg.sv
// Types shared by the timer and PWM unit
package tpwm_pkg;
  // Bus answer state, Gray ordered
  typedef enum logic [0:0] {TPWM_BUS_IDLE = 1'b0, TPWM_BUS_ACK = 1'b1} tpwm_bus_t;
  // Clock source select codes
  typedef enum logic [1:0] {
    TPWM_CLK_OFF = 2'h0,
    TPWM_CLK_BUS = 2'h1,
    TPWM_CLK_FIXED = 2'h2,
    TPWM_CLK_EXT = 2'h3
  } tpwm_clksel_t;
  // Software-written channel configuration
  typedef struct packed {
    logic ie;
    logic mode_b;
    logic mode_a;
    logic [1:0] els;
  } tpwm_chcfg_t;
  // Interrupt request levels
  typedef struct packed {
    logic overflow;
    logic [1:0] channel;
  } tpwm_irq_t;
endpackage

// >>> hdl/tpwm_top.sv
// Two-channel timer and PWM unit with Avalon-MM register slave
//
// Contract
// - Capture mode: edge select 01 rising, 10 falling, 11 both edges.
// - Compare mode: 00 software only, 01 toggle, 10 clear, 11 set.
// - Edge PWM: 10 high-true cleared on compare, X1 low-true set.
// - Center-align forces center PWM; 10 clears, X1 sets on up-compare.
// - Edge select 00 releases the pin from timer use in every mode.
// - Channel value holds capture or compare value; read/write, reset zero.
// - Capture mode: reading one value byte freezes both until other read.
// - Value byte writes buffered; pair moves after both; control write resets.
// - Center-align set makes counter up/down and all channels center PWM.
// - Clock select resets off; choices off, bus, fixed clock, external.
// - Counting pauses in debug mode; stop halts clocks; wait runs normally.
// - Up mode counts zero to terminal count, modulus or all ones, wraps.
// - Up/down counts zero to modulus and back; each end one tick long.
// - Overflow request is a level while flag and enable are both set.
// - Overflow flag sets on up wrap, or on turn down from modulus.
// - Reading one counter byte snapshots both until both are read.
// - Writing either counter byte resets counter and pending snapshot.
// - Channel flag sets on capture edge or match; writing one ignored.
// - Flag clears by read while set then write zero; new event restarts.
// - Channel request raised while channel flag and enable are set.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`include "tpwm_defines.svh"

module tpwm_top
#(
  parameter int NCH = 2
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bdm_active,
  input wire logic fixed_clk_tick,
  input wire logic [NCH-1:0] ch_pin_in,
  output logic [NCH-1:0] ch_pin_out,
  output logic [NCH-1:0] ch_pin_oe,
  output tpwm_pkg::tpwm_irq_t irq
);
  import tpwm_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tpwm_bus_t bus_state;
  logic rd_fire, wr_fire;
  logic [7:0] wbyte;
  logic sel_tsc, sel_cnth, sel_cntl, sel_modh, sel_modl;
  logic [NCH-1:0] sel_sc, sel_vh, sel_vl;
  logic [31:0] next_rdata;
  logic overflow_flag, tof_armed, overflow_irq_enable, cas;
  logic [1:0] clk_sel;
  logic [2:0] presc_sel;
  logic [6:0] presc, presc_lim;
  logic ext_s1, ext_s2, ext_s3;
  logic src_tick, tick;
  logic [15:0] cnt, next_cnt, term, modv, mod_buf;
  logic dir_up, next_dir_up, turn, ovf_evt;
  logic mod_hi_w, mod_lo_w;
  logic [15:0] snap;
  logic snap_valid, snap_hi, snap_lo;
  tpwm_chcfg_t cfg [NCH];
  logic [15:0] chv [NCH];
  logic [15:0] vbuf [NCH];
  logic [15:0] rlatch [NCH];
  logic [NCH-1:0] chf, chf_armed, vh_w, vl_w, rl_valid, rl_hi, rl_lo;
  logic [NCH-1:0] pin_q, out_q, is_ic, is_oc, is_ep, cap_evt, match, evt;
  logic [NCH-1:0] act_lvl, xfer;

  // ****************************************************************
  // Avalon-MM slave
  // ****************************************************************
  // One wait cycle per access, answer on the second cycle
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bus_state <= TPWM_BUS_IDLE;
    else if (bus_state == TPWM_BUS_IDLE && (avs_read || avs_write))
      bus_state <= TPWM_BUS_ACK;
    else
      bus_state <= TPWM_BUS_IDLE;
  end

  // Handshake and access strobes
  assign avs_waitrequest = (avs_read || avs_write) &&
                           bus_state == TPWM_BUS_IDLE;
  assign rd_fire = avs_read && bus_state == TPWM_BUS_IDLE;
  assign wr_fire = avs_write && bus_state == TPWM_BUS_ACK &&
                   avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Address decode
  always_comb
  begin
    sel_tsc = avs_address == `TPWM_OFS_TSC;
    sel_cnth = avs_address == `TPWM_OFS_CNTH;
    sel_cntl = avs_address == `TPWM_OFS_CNTL;
    sel_modh = avs_address == `TPWM_OFS_MODH;
    sel_modl = avs_address == `TPWM_OFS_MODL;
    for (int n = 0; n < NCH; n++)
    begin
      sel_sc[n] = avs_address == 6'(`TPWM_OFS_CH_BASE +
                  n * `TPWM_CH_STRIDE + `TPWM_OFS_CH_SC);
      sel_vh[n] = avs_address == 6'(`TPWM_OFS_CH_BASE +
                  n * `TPWM_CH_STRIDE + `TPWM_OFS_CH_VH);
      sel_vl[n] = avs_address == 6'(`TPWM_OFS_CH_BASE +
                  n * `TPWM_CH_STRIDE + `TPWM_OFS_CH_VL);
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    next_rdata = 32'h0;
    if (sel_tsc)
      next_rdata[7:0] = {overflow_flag, overflow_irq_enable, cas, clk_sel, presc_sel};
    else if (sel_cnth)
      next_rdata[7:0] = snap_valid ? snap[15:8] : cnt[15:8];
    else if (sel_cntl)
      next_rdata[7:0] = snap_valid ? snap[7:0] : cnt[7:0];
    else if (sel_modh)
      next_rdata[7:0] = modv[15:8];
    else if (sel_modl)
      next_rdata[7:0] = modv[7:0];
    for (int n = 0; n < NCH; n++)
    begin
      if (sel_sc[n])
        next_rdata[7:0] = {chf[n], cfg[n], 2'b00};
      else if (sel_vh[n])
        next_rdata[7:0] = (is_ic[n] && rl_valid[n]) ?
                          rlatch[n][15:8] : chv[n][15:8];
      else if (sel_vl[n])
        next_rdata[7:0] = (is_ic[n] && rl_valid[n]) ?
                          rlatch[n][7:0] : chv[n][7:0];
    end
  end

  // Read data register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0;
    else if (rd_fire)
      avs_readdata <= next_rdata;
  end

  // ****************************************************************
  // Timer status and control
  // ****************************************************************
  // Configuration fields
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      overflow_irq_enable <= 1'b0;
      cas <= 1'b0;
      clk_sel <= TPWM_CLK_OFF;
      presc_sel <= `TPWM_RST_PS;
    end
    else if (wr_fire && sel_tsc)
    begin
      overflow_irq_enable <= wbyte[`TPWM_TSC_OVERFLOW_IRQ_ENABLE];
      cas <= wbyte[`TPWM_TSC_CAS];
      clk_sel <= wbyte[`TPWM_TSC_CLKS_LO +: 2];
      presc_sel <= wbyte[`TPWM_TSC_PS_LO +: 3];
    end
  end

  // Overflow flag: set wins over the clear sequence
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      overflow_flag <= 1'b0;
      tof_armed <= 1'b0;
    end
    else if (ovf_evt)
    begin
      overflow_flag <= 1'b1;
      tof_armed <= 1'b0;
    end
    else if (rd_fire && sel_tsc && overflow_flag)
      tof_armed <= 1'b1;
    else if (wr_fire && sel_tsc && tof_armed && !wbyte[`TPWM_TSC_TOF])
    begin
      overflow_flag <= 1'b0;
      tof_armed <= 1'b0;
    end
  end

  // Interrupt request levels, one process drives the whole struct
  always_comb
  begin
    irq.overflow = overflow_flag && overflow_irq_enable;
    irq.channel = 2'b00;
    for (int n = 0; n < NCH && n < 2; n++)
      irq.channel[n] = chf[n] && cfg[n].ie;
  end

  // ****************************************************************
  // Clock source and prescaler
  // ****************************************************************
  // External clock on channel 0 pin, two-stage synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end
    else
    begin
      ext_s1 <= ch_pin_in[0];
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Source tick; edge detect needs slow external clock
  always_comb
  begin
    case (clk_sel)
      TPWM_CLK_BUS: src_tick = 1'b1;
      TPWM_CLK_FIXED: src_tick = fixed_clk_tick;
      TPWM_CLK_EXT: src_tick = ext_s2 && !ext_s3;
      default: src_tick = 1'b0;
    endcase
  end

  // Divide by two to the power of the prescale field
  assign presc_lim = 7'((8'h01 << presc_sel) - 8'h01);
  assign tick = src_tick && !bdm_active && presc == presc_lim;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      presc <= 7'h00;
    else if (src_tick && !bdm_active)
      presc <= (presc == presc_lim) ? 7'h00 : 7'(presc + 7'h01);
  end

  // ****************************************************************
  // Main counter
  // ****************************************************************
  // Next count and direction
  always_comb
  begin
    term = (modv == `TPWM_RST_WORD) ? `TPWM_CNT_MAX : modv;
    next_dir_up = dir_up;
    turn = 1'b0;
    next_cnt = 16'(cnt + 16'h0001);
    if (!cas)
    begin
      next_dir_up = 1'b1;
      if (cnt >= term)
      begin
        next_cnt = `TPWM_RST_WORD;
        turn = 1'b1;
      end
    end
    else if (dir_up)
    begin
      if (cnt >= modv)
      begin
        next_cnt = 16'(cnt - 16'h0001);
        next_dir_up = 1'b0;
        turn = 1'b1;
      end
    end
    else if (cnt == `TPWM_RST_WORD)
      next_dir_up = 1'b1;
    else
      next_cnt = 16'(cnt - 16'h0001);
  end

  assign ovf_evt = tick && turn;

  // Counter register; any byte write clears it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || (wr_fire && (sel_cnth || sel_cntl)))
    begin
      cnt <= `TPWM_RST_WORD;
      dir_up <= 1'b1;
    end
    else if (tick)
    begin
      cnt <= next_cnt;
      dir_up <= next_dir_up;
    end
  end

  // Coherent counter snapshot
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || (wr_fire && (sel_cnth || sel_cntl)))
    begin
      snap <= `TPWM_RST_WORD;
      snap_valid <= 1'b0;
      snap_hi <= 1'b0;
      snap_lo <= 1'b0;
    end
    else if (rd_fire && (sel_cnth || sel_cntl))
    begin
      if (!snap_valid)
      begin
        snap <= cnt;
        snap_valid <= 1'b1;
        snap_hi <= sel_cnth;
        snap_lo <= sel_cntl;
      end
      else if ((sel_cnth && snap_lo) || (sel_cntl && snap_hi))
      begin
        snap_valid <= 1'b0;
        snap_hi <= 1'b0;
        snap_lo <= 1'b0;
      end
    end
  end

  // Modulus byte buffers, moved as one word
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      modv <= `TPWM_RST_WORD;
      mod_buf <= `TPWM_RST_WORD;
      mod_hi_w <= 1'b0;
      mod_lo_w <= 1'b0;
    end
    else if (wr_fire && sel_tsc)
    begin
      mod_hi_w <= 1'b0;
      mod_lo_w <= 1'b0;
    end
    else if (wr_fire && sel_modh)
    begin
      mod_buf[15:8] <= wbyte;
      mod_hi_w <= 1'b1;
    end
    else if (wr_fire && sel_modl)
    begin
      mod_buf[7:0] <= wbyte;
      mod_lo_w <= 1'b1;
    end
    else if (mod_hi_w && mod_lo_w && (!cas || ovf_evt))
    begin
      modv <= mod_buf;
      mod_hi_w <= 1'b0;
      mod_lo_w <= 1'b0;
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  // Mode decode and channel events
  always_comb
  begin
    for (int n = 0; n < NCH; n++)
    begin
      is_ic[n] = !cas && !cfg[n].mode_b && !cfg[n].mode_a;
      is_oc[n] = !cas && !cfg[n].mode_b && cfg[n].mode_a;
      is_ep[n] = !cas && cfg[n].mode_b;
      act_lvl[n] = !cfg[n].els[0];
      case (cfg[n].els)
        `TPWM_ELS_01: cap_evt[n] = ch_pin_in[n] && !pin_q[n];
        `TPWM_ELS_10: cap_evt[n] = !ch_pin_in[n] && pin_q[n];
        `TPWM_ELS_11: cap_evt[n] = ch_pin_in[n] != pin_q[n];
        default: cap_evt[n] = 1'b0;
      endcase
      cap_evt[n] = cap_evt[n] && is_ic[n];
      match[n] = tick && next_cnt == chv[n] && !is_ic[n];
      evt[n] = cap_evt[n] || match[n];
      if (is_ic[n] || is_oc[n])
        xfer[n] = vh_w[n] && vl_w[n];
      else if (is_ep[n])
        xfer[n] = vh_w[n] && vl_w[n] && cnt == `TPWM_RST_WORD;
      else
        xfer[n] = vh_w[n] && vl_w[n] && ovf_evt;
      ch_pin_oe[n] = cfg[n].els != `TPWM_ELS_OFF && !is_ic[n];
    end
  end

  assign ch_pin_out = out_q;

  // Pin sample for edge detection; assumes a settled pin
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pin_q <= '0;
    else
      pin_q <= ch_pin_in;
  end

  // Configuration, flags and clear sequence
  always_ff @(posedge clk_sys)
  begin
    for (int n = 0; n < NCH; n++)
    begin
      if (!rst_n)
      begin
        cfg[n] <= '0;
        chf[n] <= 1'b0;
        chf_armed[n] <= 1'b0;
      end
      else
      begin
        if (wr_fire && sel_sc[n])
          cfg[n] <= wbyte[6:2];
        if (evt[n])
        begin
          chf[n] <= 1'b1;
          chf_armed[n] <= 1'b0;
        end
        else if (rd_fire && sel_sc[n] && chf[n])
          chf_armed[n] <= 1'b1;
        else if (wr_fire && sel_sc[n] && chf_armed[n] &&
                 !wbyte[`TPWM_CSC_FLAG])
        begin
          chf[n] <= 1'b0;
          chf_armed[n] <= 1'b0;
        end
      end
    end
  end

  // Value registers, write buffers and capture
  always_ff @(posedge clk_sys)
  begin
    for (int n = 0; n < NCH; n++)
    begin
      if (!rst_n)
      begin
        chv[n] <= `TPWM_RST_WORD;
        vbuf[n] <= `TPWM_RST_WORD;
        vh_w[n] <= 1'b0;
        vl_w[n] <= 1'b0;
      end
      else
      begin
        if (cap_evt[n])
          chv[n] <= cnt;
        else if (xfer[n])
          chv[n] <= vbuf[n];
        if (wr_fire && sel_sc[n])
        begin
          vh_w[n] <= 1'b0;
          vl_w[n] <= 1'b0;
        end
        else if (wr_fire && sel_vh[n])
        begin
          vbuf[n][15:8] <= wbyte;
          vh_w[n] <= 1'b1;
        end
        else if (wr_fire && sel_vl[n])
        begin
          vbuf[n][7:0] <= wbyte;
          vl_w[n] <= 1'b1;
        end
        else if (xfer[n])
        begin
          vh_w[n] <= 1'b0;
          vl_w[n] <= 1'b0;
        end
      end
    end
  end

  // Capture-mode read latch
  always_ff @(posedge clk_sys)
  begin
    for (int n = 0; n < NCH; n++)
    begin
      if (!rst_n || (wr_fire && sel_sc[n]))
      begin
        rlatch[n] <= `TPWM_RST_WORD;
        rl_valid[n] <= 1'b0;
        rl_hi[n] <= 1'b0;
        rl_lo[n] <= 1'b0;
      end
      else if (rd_fire && is_ic[n] && (sel_vh[n] || sel_vl[n]))
      begin
        if (!rl_valid[n])
        begin
          rlatch[n] <= chv[n];
          rl_valid[n] <= 1'b1;
          rl_hi[n] <= sel_vh[n];
          rl_lo[n] <= sel_vl[n];
        end
        else if ((sel_vh[n] && rl_lo[n]) || (sel_vl[n] && rl_hi[n]))
        begin
          rl_valid[n] <= 1'b0;
          rl_hi[n] <= 1'b0;
          rl_lo[n] <= 1'b0;
        end
      end
    end
  end

  // Pin output level per mode
  always_ff @(posedge clk_sys)
  begin
    for (int n = 0; n < NCH; n++)
    begin
      if (!rst_n)
        out_q[n] <= 1'b0;
      else if (is_oc[n])
      begin
        if (match[n])
        begin
          case (cfg[n].els)
            `TPWM_ELS_01: out_q[n] <= !out_q[n];
            `TPWM_ELS_10: out_q[n] <= 1'b0;
            `TPWM_ELS_11: out_q[n] <= 1'b1;
            default: out_q[n] <= out_q[n];
          endcase
        end
      end
      else if (is_ep[n])
      begin
        if (tick && next_cnt == `TPWM_RST_WORD)
          out_q[n] <= (chv[n] == `TPWM_RST_WORD) ?
                      !act_lvl[n] : act_lvl[n];
        else if (match[n])
          out_q[n] <= !act_lvl[n];
      end
      else if (cas)
      begin
        if (chv[n] == `TPWM_RST_WORD || chv[n][15])
          out_q[n] <= !act_lvl[n];
        else if (match[n])
          out_q[n] <= next_dir_up ? !act_lvl[n] : act_lvl[n];
      end
    end
  end

endmodule

// >>> testbench/tpwm_sva.sv
// Port-level checker for the timer and PWM unit
`timescale 1ns/100ps
module tpwm_sva
#(
  parameter int NCH = 2
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic bdm_active,
  input wire logic fixed_clk_tick,
  input wire logic [NCH-1:0] ch_pin_in,
  input wire logic [NCH-1:0] ch_pin_out,
  input wire logic [NCH-1:0] ch_pin_oe,
  input tpwm_pkg::tpwm_irq_t irq
);
  import tpwm_pkg::*;
  logic wr_done;
  // ********************
  // Bus and output checks
  // ********************
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Write accepted in this cycle
  assign wr_done = avs_write && !avs_waitrequest;
  sequence s_first;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest;
  endsequence
  chk_one_wait: assert property (s_first |=> s_answer)
    else $error("bus answer not after one wait state");
  chk_rd_upper: assert property (avs_read && !avs_waitrequest
    |-> avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
  chk_rd_hold: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata)) else $error("read data moved without read");
  chk_oe_cause: assert property ($changed(ch_pin_oe)
    |-> $past(wr_done) || !$past(rst_n)) else $error("pin enable moved");
  chk_ovf_fall: assert property ($fell(irq.overflow)
    |-> $past(wr_done) || !$past(rst_n)) else $error("overflow irq lost");
  chk_ch_fall: assert property ($fell(irq.channel[0])
    |-> $past(wr_done) || !$past(rst_n)) else $error("channel irq lost");
  chk_dbg_pause: assert property ($rose(irq.overflow)
    |-> !$past(bdm_active) || $past(wr_done)) else $error("count in debug");
  chk_rst_quiet: assert property (disable iff (1'b0)
    !rst_n |=> irq == '0 && ch_pin_oe == '0) else $error("reset not quiet");
endmodule

bind tpwm_top tpwm_sva #(.NCH(NCH)) u_tpwm_sva
(
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .bdm_active(bdm_active),
  .fixed_clk_tick(fixed_clk_tick), .ch_pin_in(ch_pin_in),
  .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .irq(irq)
);

// >>> testbench/tpwm_pin_model.sv
// Outside circuitry on the timer channel pins
`timescale 1ns/100ps
module tpwm_pin_model
#(
  parameter int NCH = 2
)
(
  input wire logic clk_sys,
  input wire logic [NCH-1:0] ext_level,
  input wire logic [NCH-1:0] ch_pin_out,
  input wire logic [NCH-1:0] ch_pin_oe,
  output logic [NCH-1:0] ch_pin_in
);
  logic [NCH-1:0] drive;
  // Outside level moves only on a clock edge, held in between
  always_ff @(posedge clk_sys)
  begin
    drive <= ext_level;
  end
  // Wire level: timer output where enabled, else outside source
  assign ch_pin_in = (ch_pin_oe & ch_pin_out) | (~ch_pin_oe & drive);
endmodule

// >>> testbench/tpwm_tb_top.sv
// Self-checking bench for the timer and PWM unit
`timescale 1ns/100ps
`include "tpwm_defines.svh"
module tpwm_tb_top;
  import tpwm_pkg::*;
  localparam logic [5:0] TSC = `TPWM_OFS_TSC;
  localparam logic [5:0] CNTH = `TPWM_OFS_CNTH;
  localparam logic [5:0] CNTL = `TPWM_OFS_CNTL;
  localparam logic [5:0] MODH = `TPWM_OFS_MODH;
  localparam logic [5:0] MODL = `TPWM_OFS_MODL;
  localparam logic [5:0] SC0 = `TPWM_OFS_CH_BASE;
  localparam logic [5:0] VH0 = SC0 + `TPWM_OFS_CH_VH;
  localparam logic [5:0] VL0 = SC0 + `TPWM_OFS_CH_VL;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic bdm_active = 1'b0;
  logic fixed_clk_tick = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] ext_level = 2'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, s;
  logic [1:0] ch_pin_in, ch_pin_out, ch_pin_oe;
  logic [7:0] q, a, cfg;
  tpwm_irq_t irq;
  int n_errors = 0;
  int checks_done = 0;

  // ********************
  // Design, pins and clock
  // ********************
  tpwm_top #(.NCH(2)) DUT
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bdm_active(bdm_active), .fixed_clk_tick(fixed_clk_tick),
    .ch_pin_in(ch_pin_in), .ch_pin_out(ch_pin_out),
    .ch_pin_oe(ch_pin_oe), .irq(irq)
  );
  tpwm_pin_model #(.NCH(2)) u_pins
  (
    .clk_sys(clk_sys), .ext_level(ext_level), .ch_pin_out(ch_pin_out),
    .ch_pin_oe(ch_pin_oe), .ch_pin_in(ch_pin_in)
  );
  // 25 MHz clock
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  // ********************
  // Helpers
  // ********************
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
      $display("[FAIL] %0t ns: got %h, expected %h", $time, g, e);
    if (g !== e)
      n_errors++;
  endtask
  // Avalon access, held until waitrequest is seen low
  task bus(input logic w, input logic [5:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= ad;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    @(posedge clk_sys);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk(8'(n), 8'h02);
    @(posedge clk_sys);
  endtask
  task wr(input logic [5:0] ad, input logic [7:0] d);
    bus(1'b1, ad, d);
  endtask
  task rd(input logic [5:0] ad);
    bus(1'b0, ad, 8'h00);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Wait a bounded time for channel 0 request
  task wirq(input int lim);
    s = 1'b0;
    for (int i = 0; i < lim && s !== 1'b1; i++)
    begin
      @(negedge clk_sys);
      s = irq.channel[0];
    end
    @(posedge clk_sys);
  endtask
  // Flag clear: read status then write it back with flag zero
  task clr;
    rd(SC0);
    wr(SC0, cfg);
  endtask

  // ********************
  // Scenarios
  // ********************
  task t_reset;
    rd(TSC);
    chk(q, 8'h00);
    rd(VH0);
    chk(q, 8'h00);
    rd(VL0);
    chk(q, 8'h00);
    rd(6'h30);
    chk(q, 8'h00);
    chk({5'h0, irq}, 8'h00);
    wr(SC0, 8'h10);
    wr(VH0, 8'h12);
    wr(VL0, 8'h34);
    rd(VH0);
    chk(q, 8'h12);
    rd(VL0);
    chk(q, 8'h34);
    wr(VH0, 8'h56);
    wr(SC0, 8'h10);
    wr(VL0, 8'h78);
    rd(VH0);
    chk(q, 8'h12);
  endtask
  task t_counter;
    wr(TSC, 8'h08);
    rd(CNTL);
    a = q;
    cyc(3);
    rd(CNTL);
    chk(q, a);
    rd(CNTH);
    chk(q, 8'h00);
    rd(CNTL);
    chk(q, a + 8'd12);
    wr(CNTH, 8'h00);
    rd(CNTL);
    chk({7'h0, q < 8'h04}, 8'h01);
    rd(CNTH);
    wr(TSC, 8'h00);
    wr(MODH, 8'h00);
    wr(MODL, 8'h03);
    wr(CNTL, 8'h00);
    wr(TSC, 8'h08);
    cyc(8);
    chk({7'h0, irq.overflow}, 8'h00);
    rd(CNTL);
    chk({7'h0, q < 8'h04}, 8'h01);
    rd(CNTH);
    wr(TSC, 8'h48);
    chk({7'h0, irq.overflow}, 8'h01);
    rd(TSC);
    chk(q, 8'hc8);
    // Stop counting so no new overflow disarms the clear
    wr(TSC, 8'h40);
    rd(TSC);
    wr(TSC, 8'h40);
    chk({7'h0, irq.overflow}, 8'h00);
  endtask
  task t_debug;
    wr(TSC, 8'h08);
    bdm_active <= 1'b1;
    rd(CNTL);
    a = q;
    rd(CNTH);
    cyc(5);
    rd(CNTL);
    chk(q, a);
    rd(CNTH);
    bdm_active <= 1'b0;
    wr(TSC, 8'h00);
  endtask
  task t_compare;
    wr(MODH, 8'h00);
    wr(MODL, 8'h00);
    for (int k = 1; k < 4; k++)
    begin
      wr(SC0, {4'h5, k[1:0], 2'h0});
      wr(VH0, 8'h00);
      wr(VL0, 8'h20);
      wr(CNTL, 8'h00);
      wr(TSC, 8'h08);
      wirq(80);
      chk({7'h0, s}, 8'h01);
      chk({6'h0, ch_pin_oe[0], ch_pin_out[0]}, {7'h1, k != 2});
      wr(TSC, 8'h00);
      rd(SC0);
      chk(q, {4'hd, k[1:0], 2'h0});
    end
    wr(SC0, 8'hd4);
    chk({7'h0, irq.channel[0]}, 8'h01);
    rd(SC0);
    wr(SC0, 8'h50);
    chk({6'h0, irq.channel[0], ch_pin_oe[0]}, 8'h00);
  endtask
  task t_capture;
    wr(TSC, 8'h08);
    for (int k = 1; k < 4; k++)
    begin
      ext_level <= 2'h0;
      cyc(3); // pin settled two clocks before capture mode
      cfg = {4'h4, k[1:0], 2'h0};
      wr(SC0, cfg);
      clr;
      ext_level <= 2'h1;
      wirq(12);
      chk({7'h0, s}, {7'h0, k[0]});
      clr;
      ext_level <= 2'h0;
      wirq(12);
      chk({7'h0, s}, {7'h0, k[1]});
      clr;
    end
    rd(VL0);
    a = q;
    ext_level <= 2'h1;
    wirq(12);
    rd(VL0);
    chk(q, a);
    rd(VH0);
    rd(VL0);
    chk({7'h0, q !== a}, 8'h01);
    wr(TSC, 8'h00);
  endtask
  task t_pwm;
    int cnt;
    for (int e = 0; e < 4; e++)
    begin
      wr(TSC, 8'h00);
      wr(MODH, 8'h00);
      wr(MODL, e < 2 ? 8'h07 : 8'h04);
      wr(SC0, e[0] ? 8'h24 : 8'h28);
      wr(VH0, 8'h00);
      wr(VL0, e < 2 ? 8'h03 : 8'h02);
      wr(CNTL, 8'h00);
      wr(TSC, e < 2 ? 8'h08 : 8'h28);
      cyc(24);
      cnt = 0;
      repeat (16)
      begin
        @(negedge clk_sys);
        cnt += ch_pin_out[0];
      end
      @(posedge clk_sys);
      chk(8'(cnt), e > 1 ? 8'd8 : (e[0] ? 8'd10 : 8'd6));
    end
    wr(TSC, 8'h00);
  endtask
  // External pin clock and fixed clock with prescaler
  task t_clock;
    wr(SC0, 8'h00);
    ext_level <= 2'h0;
    wr(CNTL, 8'h00);
    wr(TSC, 8'h18);
    repeat (4)
    begin
      ext_level <= 2'h1;
      cyc(2);
      ext_level <= 2'h0;
      cyc(3); // edges below a quarter of the bus rate
    end
    rd(CNTL);
    chk(q, 8'h04);
    rd(CNTH);
    wr(TSC, 8'h00);
    wr(CNTL, 8'h00);
    wr(TSC, 8'h11);
    repeat (6)
    begin
      fixed_clk_tick <= 1'b1;
      cyc(1);
      fixed_clk_tick <= 1'b0;
      cyc(1);
    end
    rd(CNTL);
    chk(q, 8'h03);
    rd(CNTH);
    wr(TSC, 8'h00);
  endtask

  // ********************
  // Run control
  // ********************
  task give_verdict;
    if (n_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_counter;
    t_debug;
    t_compare;
    t_capture;
    t_pwm;
    t_clock;
    give_verdict;
  end
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    give_verdict;
  end
endmodule
